// ### pkg/qenc_pkg.sv
package qenc_pkg;

   // ----------------------------------------------------------------
   // Modes and feature configuration
   // ----------------------------------------------------------------
   typedef enum logic {MODE_QUAD, MODE_UPDN} mode_t;
   typedef enum logic [1:0] {EVAL_X1, EVAL_X2, EVAL_X4} eval_t;

   // Diff bits: [0] track A, [1] track B, [2] track C complementary
   typedef struct packed {
      mode_t mode;
      eval_t eval;
      logic period_en;
      logic [2:0] diff;
   } feature_t;

   localparam feature_t FEATURE_RST = '{mode: MODE_QUAD, eval: EVAL_X4, period_en: 1'b0, diff: 3'h7};

   // ----------------------------------------------------------------
   // Control and status byte fields
   // ----------------------------------------------------------------
   localparam int CTL_ZERO_ARM = 0;
   localparam int CTL_EXT_ARM = 1;
   localparam int CTL_SET = 2;
   localparam int CTL_ACK = 3;

   localparam int STS_ZERO_LAT = 0;
   localparam int STS_EXT_LAT = 1;
   localparam int STS_SET_DONE = 2;
   localparam int STS_OVF = 3;
   localparam int STS_UNF = 4;
   localparam int STS_ENC_STAT = 5;
   localparam int STS_GATED = 6;

   // ----------------------------------------------------------------
   // Process images, control/status byte at lowest offset
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [15:0] rsvd_word;
      logic [7:0] rsvd_byte;
      logic [15:0] count_word;
      logic [7:0] control;
   } out_image_t;

   typedef struct packed {
      logic [15:0] latch_word;
      logic [7:0] period_extra_byte;
      logic [15:0] count_word;
      logic [7:0] status;
   } in_image_t;

   typedef struct packed {
      logic trk_a;
      logic trk_b;
      logic trk_c;
      logic enc_status;
      logic gate;
      logic ext_latch;
      logic run;
   } led_t;

   // ----------------------------------------------------------------
   // Timing
   // ----------------------------------------------------------------
   localparam int CLK_PERIOD_NS = 25;
   localparam int CLK_HZ = 40_000_000;
   localparam int PERIOD_RES_NS = 200;
   localparam int PERIOD_TICK_CYC = PERIOD_RES_NS / CLK_PERIOD_NS;
   localparam int RUN_TIMEOUT_MS = 100;
   localparam int RUN_TIMEOUT_CYC = RUN_TIMEOUT_MS * (CLK_HZ / 1000);

endpackage

// ### core/quadrature_encoder_counter.sv
// Functional notes
// (RQ1) 16-bit position counter from quadrature decoder; host reads it and loads it.
// (RQ2) 1x, 2x or 4x evaluation; each track single-ended or complementary.
// (RQ3) Reset default: quadrature mode, 4x, all three tracks complementary.
// (RQ4) Encoder mode treats B as the phase-shifted companion of A.
// (RQ5) Zero pulse on C latches the counter only while zero arm is set.
// (RQ6) External latch rising edge latches the counter while external arm is set.
// (RQ7) No counting while external gate input is high.
// (RQ8) Up/down mode counts A rising edges; B low up, B high down.
// (RQ9) Up/down mode: C low enables counting, C high disables.
// (RQ10) Period mode measures A rising-to-rising time in 200 ns units.
// (RQ11) Overflow past maximum and underflow past zero are reported.
// (RQ12) Run indicator off after 100 ms without process data exchange.
// (RQ13) Six bytes each way; control/status byte at lowest offset.
// (RQ14) First word holds counter (read and set); last word holds latch.
// (RQ15) Period mode returns period over extra byte plus latch word.
// (RQ16) Operating mode chosen through the feature configuration.
// (RQ17) Indicators mirror A, B, C, status input, gate and external latch.
// (RQ18) Quadrature: up when A leads B, down when B leads; wraps mod 2^16.
// (RQ19) Encoder inputs pass two flip-flops before edge detection.
`timescale 1ns/1ps

module quadrature_encoder_counter #(
   parameter int RUN_TIMEOUT = qenc_pkg::RUN_TIMEOUT_CYC,
   parameter int PERIOD_W = 24
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic ENC_A,
   input wire logic ENC_A_N,
   input wire logic ENC_B,
   input wire logic ENC_B_N,
   input wire logic ENC_C,
   input wire logic ENC_C_N,
   input wire logic EXT_LATCH,
   input wire logic EXT_GATE,
   input wire logic ENC_STATUS,
   input wire logic PD_WR,
   input wire qenc_pkg::out_image_t PD_OUT,
   output qenc_pkg::in_image_t PD_IN,
   input wire logic FEAT_WR,
   input wire qenc_pkg::feature_t FEAT_IN,
   output qenc_pkg::feature_t FEAT_OUT,
   output qenc_pkg::led_t LED
);

   // ----------------------------------------------------------------
   // Input synchronisers
   // ----------------------------------------------------------------
   localparam int NSYNC = 9;
   logic [NSYNC-1:0] pins;
   logic [NSYNC-1:0] sync1_r, sync2_r;

   assign pins = {ENC_STATUS, EXT_GATE, EXT_LATCH, ENC_C_N, ENC_C, ENC_B_N, ENC_B, ENC_A_N, ENC_A};

   // Two stages on every pin; only stage two is read by logic
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         sync1_r <= '0;
         sync2_r <= '0;
      end else begin
         sync1_r <= pins; // RQ19
         sync2_r <= sync1_r; // RQ19
      end
   end

   // ----------------------------------------------------------------
   // Feature configuration
   // ----------------------------------------------------------------
   qenc_pkg::feature_t feat_r, feat_nxt;

   // Written by the host, reset to the delivery defaults
   always_comb begin
      feat_nxt = feat_r;
      if (FEAT_WR) begin
         feat_nxt = FEAT_IN; // RQ16 RQ2
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         feat_r <= qenc_pkg::FEATURE_RST; // RQ3
      end else begin
         feat_r <= feat_nxt;
      end
   end

   assign FEAT_OUT = feat_r;

   // ----------------------------------------------------------------
   // Track interpretation and edge detection
   // ----------------------------------------------------------------
   // Complementary: a track is high only when the pair disagrees that way,
   // so a broken wire or common-mode glitch reads as low, not as a pulse.
   function automatic logic track(input logic p, input logic n, input logic diff);
      track = diff ? (p & ~n) : p;
   endfunction

   logic trk_a, trk_b, trk_c, ext_latch, gate;
   logic prev_a_r, prev_b_r, prev_c_r, prev_l_r;

   assign trk_a = track(sync2_r[0], sync2_r[1], feat_r.diff[0]); // RQ2
   assign trk_b = track(sync2_r[2], sync2_r[3], feat_r.diff[1]); // RQ2
   assign trk_c = track(sync2_r[4], sync2_r[5], feat_r.diff[2]); // RQ2
   assign ext_latch = sync2_r[6];
   assign gate = sync2_r[7];

   // Previous levels for edge detection
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         prev_a_r <= 1'b0;
         prev_b_r <= 1'b0;
         prev_c_r <= 1'b0;
         prev_l_r <= 1'b0;
      end else begin
         prev_a_r <= trk_a;
         prev_b_r <= trk_b;
         prev_c_r <= trk_c;
         prev_l_r <= ext_latch;
      end
   end

   logic a_rise, a_fall, b_rise, b_fall, c_rise, l_rise;

   assign a_rise = trk_a & ~prev_a_r;
   assign a_fall = ~trk_a & prev_a_r;
   assign b_rise = trk_b & ~prev_b_r;
   assign b_fall = ~trk_b & prev_b_r;
   assign c_rise = trk_c & ~prev_c_r;
   assign l_rise = ext_latch & ~prev_l_r;

   // ----------------------------------------------------------------
   // Step decode
   // ----------------------------------------------------------------
   logic step, up;

   // In quadrature mode, simultaneous A and B edges are an illegal jump and are ignored
   always_comb begin
      step = 1'b0;
      up = 1'b0;
      if (feat_r.mode == qenc_pkg::MODE_UPDN) begin
         step = a_rise & ~trk_c; // RQ8 RQ9
         up = ~trk_b; // RQ8
      end else if (!((a_rise | a_fall) && (b_rise | b_fall))) begin
         unique case (feat_r.eval)
            qenc_pkg::EVAL_X1: begin
               // Only rising A in forward, falling A in reverse: one count per cycle
               step = (a_rise & ~trk_b) | (a_fall & ~trk_b);
               up = a_rise;
            end
            qenc_pkg::EVAL_X2: begin
               step = a_rise | a_fall; // RQ4
               up = a_rise ? ~trk_b : trk_b; // RQ18
            end
            qenc_pkg::EVAL_X4: begin
               step = a_rise | a_fall | b_rise | b_fall; // RQ4
               up = (a_rise & ~trk_b) | (a_fall & trk_b) | (b_rise & trk_a) | (b_fall & ~trk_a); // RQ18
            end
            default: ; // Code 3 is illegal: no counting
         endcase
      end
      if (gate) begin
         step = 1'b0; // RQ7
      end
   end

   // ----------------------------------------------------------------
   // Counter, latch and flags
   // ----------------------------------------------------------------
   logic [15:0] count_r, count_nxt, latch_r, latch_nxt;
   logic [7:0] ctrl_r, ctrl_nxt;
   logic zlat_r, zlat_nxt, elat_r, elat_nxt, setd_r, setd_nxt;
   logic ovf_r, ovf_nxt, unf_r, unf_nxt, ack;

   assign ack = PD_WR & PD_OUT.control[qenc_pkg::CTL_ACK];

   // Host set wins over a step in the same cycle; flag sets win over ack
   always_comb begin
      count_nxt = count_r;
      latch_nxt = latch_r;
      ctrl_nxt = ctrl_r;
      zlat_nxt = zlat_r & ~ack;
      elat_nxt = elat_r & ~ack;
      setd_nxt = setd_r & ~ack;
      ovf_nxt = ovf_r & ~ack;
      unf_nxt = unf_r & ~ack;
      if (PD_WR) begin
         ctrl_nxt = PD_OUT.control;
      end
      if (PD_WR && PD_OUT.control[qenc_pkg::CTL_SET]) begin
         count_nxt = PD_OUT.count_word; // RQ1 RQ14
         setd_nxt = 1'b1;
      end else if (step) begin
         count_nxt = up ? 16'(count_r + 16'h0001) : 16'(count_r - 16'h0001); // RQ1 RQ18
         if (up && count_r == 16'hFFFF) begin
            ovf_nxt = 1'b1; // RQ11
         end
         if (!up && count_r == 16'h0000) begin
            unf_nxt = 1'b1; // RQ11
         end
      end
      if (c_rise && ctrl_r[qenc_pkg::CTL_ZERO_ARM]) begin
         latch_nxt = count_r; // RQ5
         zlat_nxt = 1'b1;
      end else if (l_rise && ctrl_r[qenc_pkg::CTL_EXT_ARM]) begin
         latch_nxt = count_r; // RQ6
         elat_nxt = 1'b1;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         count_r <= 16'h0000;
         latch_r <= 16'h0000;
         ctrl_r <= 8'h00;
         zlat_r <= 1'b0;
         elat_r <= 1'b0;
         setd_r <= 1'b0;
         ovf_r <= 1'b0;
         unf_r <= 1'b0;
      end else begin
         count_r <= count_nxt;
         latch_r <= latch_nxt;
         ctrl_r <= ctrl_nxt;
         zlat_r <= zlat_nxt;
         elat_r <= elat_nxt;
         setd_r <= setd_nxt;
         ovf_r <= ovf_nxt;
         unf_r <= unf_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Period measurement
   // ----------------------------------------------------------------
   localparam logic [3:0] TICK_LAST = 4'(qenc_pkg::PERIOD_TICK_CYC - 1);
   logic [3:0] pre_r, pre_nxt;
   logic [PERIOD_W-1:0] pcnt_r, pcnt_nxt, period_r, period_nxt;

   // Saturates instead of wrapping, so an over-range period reads as maximum once A rises again
   always_comb begin
      pre_nxt = (pre_r == TICK_LAST) ? 4'h0 : 4'(pre_r + 4'h1);
      pcnt_nxt = pcnt_r;
      period_nxt = period_r;
      if (pre_r == TICK_LAST && pcnt_r != '1) begin
         pcnt_nxt = PERIOD_W'(pcnt_r + 1'b1); // RQ10
      end
      // Capture takes a tick landing on the same edge, else a whole tick is lost
      if (a_rise) begin
         period_nxt = pcnt_nxt; // RQ10
         pcnt_nxt = '0;
         pre_nxt = 4'h0;
      end
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         pre_r <= 4'h0;
         pcnt_r <= '0;
         period_r <= '0;
      end else begin
         pre_r <= pre_nxt;
         pcnt_r <= pcnt_nxt;
         period_r <= period_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Run watchdog
   // ----------------------------------------------------------------
   localparam int RUN_W = $clog2(RUN_TIMEOUT + 1);
   logic [RUN_W-1:0] run_cnt_r, run_cnt_nxt;

   // Restarted by every exchange; saturates at the timeout
   always_comb begin
      run_cnt_nxt = run_cnt_r;
      if (PD_WR) begin
         run_cnt_nxt = '0; // RQ12
      end else if (run_cnt_r != RUN_W'(RUN_TIMEOUT)) begin
         run_cnt_nxt = RUN_W'(run_cnt_r + 1'b1);
      end
   end

   // Starts expired so the indicator stays dark until the first exchange
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         run_cnt_r <= RUN_W'(RUN_TIMEOUT);
      end else begin
         run_cnt_r <= run_cnt_nxt;
      end
   end

   // ----------------------------------------------------------------
   // Input image and indicators
   // ----------------------------------------------------------------
   qenc_pkg::in_image_t img_r, img_nxt;
   qenc_pkg::led_t led_r, led_nxt;

   always_comb begin
      img_nxt.status = 8'h00; // RQ13
      img_nxt.status[qenc_pkg::STS_ZERO_LAT] = zlat_r;
      img_nxt.status[qenc_pkg::STS_EXT_LAT] = elat_r;
      img_nxt.status[qenc_pkg::STS_SET_DONE] = setd_r;
      img_nxt.status[qenc_pkg::STS_OVF] = ovf_r; // RQ11
      img_nxt.status[qenc_pkg::STS_UNF] = unf_r; // RQ11
      img_nxt.status[qenc_pkg::STS_ENC_STAT] = sync2_r[8];
      img_nxt.status[qenc_pkg::STS_GATED] = gate;
      img_nxt.count_word = count_r; // RQ14
      if (feat_r.period_en) begin
         {img_nxt.latch_word, img_nxt.period_extra_byte} = 24'(period_r); // RQ15
      end else begin
         img_nxt.latch_word = latch_r; // RQ14
         img_nxt.period_extra_byte = 8'h00;
      end
      led_nxt = '{trk_a: trk_a, trk_b: trk_b, trk_c: trk_c, enc_status: sync2_r[8],
                  gate: gate, ext_latch: ext_latch, run: run_cnt_r != RUN_W'(RUN_TIMEOUT)}; // RQ17 RQ12
   end

   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         img_r <= '0;
         led_r <= '0;
      end else begin
         img_r <= img_nxt;
         led_r <= led_nxt;
      end
   end

   assign PD_IN = img_r;
   assign LED = led_r;

endmodule // quadrature_encoder_counter

// ### test/enc_model.sv
`timescale 1ns/1ps
module enc_model (
   output logic a,
   output logic an,
   output logic b,
   output logic bn,
   output logic c,
   output logic cn
);
   // Single-ended wiring parks the inverted pins high
   logic se = 1'b0;
   int ph = 0;

   // Track levels with true and inverted pins, each held 4 clocks
   task automatic drv(input logic va, input logic vb, input logic vc);
      a = va;
      b = vb;
      c = vc;
      an = se | ~va;
      bn = se | ~vb;
      cn = se | ~vc;
      #100;
   endtask

   // Quadrature steps: A leads B going up, B leads going down
   task automatic step(input int n);
      repeat (n < 0 ? -n : n) begin
         ph = n > 0 ? ph + 1 : ph + 3;
         drv((ph & 3) inside {1, 2}, (ph & 3) inside {2, 3}, 1'b0);
      end
   endtask

   // Zero track pulse at the present A and B levels
   task automatic zero();
      drv(a, b, 1'b1);
      drv(a, b, 1'b0);
   endtask

   // Counting pulses on A, gap stretches the period
   task automatic pulse(input int n, input logic vb, input logic vc, input int gap);
      drv(1'b0, vb, vc);
      repeat (n) begin
         drv(1'b1, vb, vc);
         drv(1'b0, vb, vc);
         #(gap);
      end
   endtask

   initial drv(1'b0, 1'b0, 1'b0);
endmodule // enc_model

// ### test/qenc_monitor.sv
`timescale 1ns/1ps
module qenc_monitor #(
   parameter int RUN_TIMEOUT = 50
) (
   input wire logic CLK,
   input wire logic RST,
   input wire logic EXT_GATE,
   input wire logic ENC_STATUS,
   input wire logic PD_WR,
   input wire qenc_pkg::out_image_t PD_OUT,
   input wire qenc_pkg::in_image_t PD_IN,
   input wire logic FEAT_WR,
   input wire qenc_pkg::feature_t FEAT_IN,
   input wire qenc_pkg::feature_t FEAT_OUT,
   input wire qenc_pkg::led_t LED
);
   default clocking cb @(posedge CLK);
   endclocking
   default disable iff (RST);

   // Cycles since last exchange, saturating past the run limit
   int idle_r;
   int idle_nxt;
   always_comb begin
      idle_nxt = idle_r > RUN_TIMEOUT + 2 ? idle_r : idle_r + 1;
      if (PD_WR) begin
         idle_nxt = 0;
      end
   end
   always_ff @(posedge CLK or posedge RST) begin
      if (RST) begin
         idle_r <= RUN_TIMEOUT + 3;
      end else begin
         idle_r <= idle_nxt;
      end
   end

   // -------------------------------------------
   // Set request, then image carries it 2 edges on
   // -------------------------------------------
   sequence set_req;
      PD_WR && PD_OUT.control[qenc_pkg::CTL_SET];
   endsequence
   sequence set_seen;
      ##2 PD_IN.count_word == $past(PD_OUT.count_word, 2) && PD_IN.status[qenc_pkg::STS_SET_DONE];
   endsequence

   set_load_a: assert property (set_req |-> set_seen)
      else $error("count set not seen in image");
   feat_load_a: assert property (FEAT_WR |=> FEAT_OUT == $past(FEAT_IN))
      else $error("feature not loaded");
   feat_hold_a: assert property (!FEAT_WR |=> $stable(FEAT_OUT))
      else $error("feature changed without write");
   // Gate held long enough that no step is still in flight
   gate_hold_a: assert property ((EXT_GATE && !PD_WR) [*8] |-> $stable(PD_IN.count_word))
      else $error("count moved while gated");
   gate_flag_a: assert property (EXT_GATE [*6] |-> PD_IN.status[qenc_pkg::STS_GATED])
      else $error("gate status missing");
   enc_stat_a: assert property ($stable(ENC_STATUS) [*6] |-> PD_IN.status[qenc_pkg::STS_ENC_STAT] == ENC_STATUS)
      else $error("encoder status not mirrored");
   led_gate_a: assert property ($stable(EXT_GATE) [*6] |-> LED.gate == EXT_GATE)
      else $error("gate indicator wrong");
   // Without a set, the count moves by at most one, modulo 2^16
   step_one_a: assert property (!$past(PD_WR, 2) |-> 16'(PD_IN.count_word - $past(PD_IN.count_word) + 16'h1) <= 16'h2)
      else $error("count jumped");
   run_on_a: assert property (PD_WR |-> ##[1:2] LED.run)
      else $error("run indicator not lit");
   run_off_a: assert property (idle_r > RUN_TIMEOUT + 2 |-> !LED.run)
      else $error("run indicator stuck on");
endmodule // qenc_monitor

// ### test/tb_quadrature_encoder_counter.sv
`timescale 1ns/1ps
module tb_quadrature_encoder_counter;
   localparam int RUN_T = 50;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic ext_latch = 1'b0;
   logic ext_gate = 1'b0;
   logic enc_status = 1'b0;
   logic pd_wr = 1'b0;
   logic feat_wr = 1'b0;
   logic a, an, b, bn, c, cn;
   qenc_pkg::out_image_t pd_out = '0;
   qenc_pkg::in_image_t pd_in;
   qenc_pkg::feature_t feat_in = qenc_pkg::FEATURE_RST;
   qenc_pkg::feature_t feat_out;
   qenc_pkg::led_t led;
   int err_total = 0;
   int checks = 0;

   always #12.5 clk = ~clk;

   enc_model u_enc (.a(a), .an(an), .b(b), .bn(bn), .c(c), .cn(cn));
   quadrature_encoder_counter #(.RUN_TIMEOUT(RUN_T)) u_dut (.CLK(clk), .RST(rst), .ENC_A(a), .ENC_A_N(an),
      .ENC_B(b), .ENC_B_N(bn), .ENC_C(c), .ENC_C_N(cn), .EXT_LATCH(ext_latch), .EXT_GATE(ext_gate),
      .ENC_STATUS(enc_status), .PD_WR(pd_wr), .PD_OUT(pd_out), .PD_IN(pd_in), .FEAT_WR(feat_wr),
      .FEAT_IN(feat_in), .FEAT_OUT(feat_out), .LED(led));

   // --------------------
   // Compares and drivers
   // --------------------
   task automatic chk(input string what, input logic [23:0] exp, input logic [23:0] got);
      checks++;
      if (got !== exp) begin
         err_total++;
         $display("ERROR %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic chk_rng(input string what, input logic [23:0] lo, input logic [23:0] hi, input logic [23:0] got);
      checks++;
      if ((got >= lo && got <= hi) !== 1'b1) begin
         err_total++;
         $display("ERROR %s expected %h..%h seen %h", what, lo, hi, got);
      end
   endtask

   // Long enough for sync, count and image stages to land
   task automatic settle();
      repeat (8) @(posedge clk);
      #2;
   endtask

   task automatic wr(input logic [7:0] ctl, input logic [15:0] cw);
      pd_out.control = ctl;
      pd_out.count_word = cw;
      pd_wr = 1'b1;
      @(posedge clk);
      #2;
      pd_wr = 1'b0;
      settle();
   endtask

   task automatic feat(input qenc_pkg::mode_t m, input qenc_pkg::eval_t e, input logic p, input logic [2:0] d);
      feat_in = '{mode: m, eval: e, period_en: p, diff: d};
      feat_wr = 1'b1;
      @(posedge clk);
      #2;
      feat_wr = 1'b0;
      settle();
      chk("feature", feat_in, feat_out);
   endtask

   // ---------
   // Scenarios
   // ---------
   task automatic t_reset();
      chk("feature", qenc_pkg::FEATURE_RST, feat_out);
      chk("count", 16'h0, pd_in.count_word);
      chk("led", 7'h0, led);
      $display("reset done");
   endtask

   task automatic t_quad();
      qenc_pkg::eval_t ev [3] = '{qenc_pkg::EVAL_X4, qenc_pkg::EVAL_X2, qenc_pkg::EVAL_X1};
      for (int i = 0; i < 3; i++) begin
         feat(qenc_pkg::MODE_QUAD, ev[i], 1'b0, 3'h7);
         wr(8'h04, 16'h0100);
         u_enc.step(4);
         settle();
         chk("count up", 16'h0100 + (16'h4 >> i), pd_in.count_word);
         u_enc.step(-8);
         settle();
         chk("count down", 16'h0100 - (16'h4 >> i), pd_in.count_word);
      end
      u_enc.se = 1'b1;
      feat(qenc_pkg::MODE_QUAD, qenc_pkg::EVAL_X4, 1'b0, 3'h0);
      u_enc.step(4);
      settle();
      chk("single ended", 16'h0103, pd_in.count_word);
      u_enc.se = 1'b0;
      feat(qenc_pkg::MODE_QUAD, qenc_pkg::EVAL_X4, 1'b0, 3'h7);
      $display("quad done");
   endtask

   task automatic t_wrap();
      wr(8'h04, 16'hFFFF);
      u_enc.step(1);
      settle();
      chk("wrap up", 16'h0000, pd_in.count_word);
      chk("a led", 1'b1, led.trk_a);
      chk("overflow", 1'b1, pd_in.status[qenc_pkg::STS_OVF]);
      wr(8'h08, 16'h0000);
      chk("ack", 1'b0, pd_in.status[qenc_pkg::STS_OVF]);
      u_enc.step(-1);
      settle();
      chk("wrap down", 16'hFFFF, pd_in.count_word);
      chk("underflow", 1'b1, pd_in.status[qenc_pkg::STS_UNF]);
      $display("wrap done");
   endtask

   task automatic t_latch();
      wr(8'h05, 16'h0055);
      u_enc.zero();
      settle();
      chk("zero latch", 16'h0055, pd_in.latch_word);
      chk("zero flag", 1'b1, pd_in.status[qenc_pkg::STS_ZERO_LAT]);
      wr(8'h04, 16'h0066);
      u_enc.zero();
      settle();
      chk("unarmed", 16'h0055, pd_in.latch_word);
      wr(8'h06, 16'h0077);
      ext_latch = 1'b1;
      settle();
      chk("latch led", 1'b1, led.ext_latch);
      ext_latch = 1'b0;
      chk("ext latch", 16'h0077, pd_in.latch_word);
      chk("ext flag", 1'b1, pd_in.status[qenc_pkg::STS_EXT_LAT]);
      $display("latch done");
   endtask

   task automatic t_gate();
      wr(8'h04, 16'h0200);
      ext_gate = 1'b1;
      enc_status = 1'b1;
      settle();
      u_enc.step(4);
      settle();
      chk("gated", 16'h0200, pd_in.count_word);
      chk("status in", 1'b1, pd_in.status[qenc_pkg::STS_ENC_STAT]);
      chk("gate led", 1'b1, led.gate);
      chk("status led", 1'b1, led.enc_status);
      ext_gate = 1'b0;
      enc_status = 1'b0;
      settle();
      u_enc.step(4);
      settle();
      chk("ungated", 16'h0204, pd_in.count_word);
      $display("gate done");
   endtask

   task automatic t_updn();
      feat(qenc_pkg::MODE_UPDN, qenc_pkg::EVAL_X4, 1'b0, 3'h7);
      wr(8'h04, 16'h0300);
      u_enc.pulse(3, 1'b0, 1'b0, 0);
      settle();
      chk("up", 16'h0303, pd_in.count_word);
      u_enc.pulse(2, 1'b1, 1'b0, 0);
      settle();
      chk("down", 16'h0301, pd_in.count_word);
      chk("b led", 1'b1, led.trk_b);
      u_enc.pulse(2, 1'b0, 1'b1, 0);
      settle();
      chk("c gate", 16'h0301, pd_in.count_word);
      chk("c led", 1'b1, led.trk_c);
      // Edges 2000 ns apart give ten ticks of 200 ns
      feat(qenc_pkg::MODE_UPDN, qenc_pkg::EVAL_X4, 1'b1, 3'h7);
      u_enc.pulse(3, 1'b0, 1'b0, 1800);
      chk_rng("period", 24'h9, 24'hB, {pd_in.latch_word, pd_in.period_extra_byte});
      $display("updn done");
   endtask

   task automatic t_run();
      wr(8'h00, 16'h0000);
      chk("run on", 1'b1, led.run);
      repeat (RUN_T + 4) @(posedge clk);
      #2;
      chk("run off", 1'b0, led.run);
      $display("run done");
   endtask

   task automatic results();
      $display("checks %0d mismatches %0d", checks, err_total);
      if (err_total == 0 && checks > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #2;
      rst = 1'b0;
      settle();
      t_reset();
      t_quad();
      t_wrap();
      t_latch();
      t_gate();
      t_updn();
      t_run();
      results();
   end

   // Tests need well under 100 us; four times that means a hang
   initial begin
      #400_000;
      err_total++;
      results();
   end
endmodule // tb_quadrature_encoder_counter

bind quadrature_encoder_counter qenc_monitor #(.RUN_TIMEOUT(RUN_TIMEOUT)) u_mon (.CLK(CLK), .RST(RST),
   .EXT_GATE(EXT_GATE), .ENC_STATUS(ENC_STATUS), .PD_WR(PD_WR), .PD_OUT(PD_OUT), .PD_IN(PD_IN),
   .FEAT_WR(FEAT_WR), .FEAT_IN(FEAT_IN), .FEAT_OUT(FEAT_OUT), .LED(LED));
